//--- rtl/pspc_duty_gen.sv
`timescale 1ns/1ns
// =====================================================================
// eight-slot stop-clock duty generator
// =====================================================================
module pspc_duty_gen #(
  parameter int SLOT_CYC = pspc_pkg::SLOT_CYC
) (
  // clock and reset
  input wire logic    CLK,
  input wire logic    RST_N,
  // throttle link
  pspc_thr_if.gen     thr
);

  logic [15:0] slot_cnt_reg;
  logic [2:0]  slot_idx_reg;
  logic        stop_reg;
  logic [3:0]  active_slots;
  logic        slot_end;
  logic        stop_next;

  // slots asserted per period: code 1 gives 7, code 7 gives 1, code 0 none
  assign active_slots = (thr.ratio == 3'h0) ? 4'h0 : 4'(4'h8 - {1'b0, thr.ratio});
  assign slot_end     = (slot_cnt_reg == 16'(SLOT_CYC - 1));
  assign stop_next    = thr.run && ({1'b0, slot_idx_reg} < active_slots);

  // slot timer, held at the start of a period while idle
  always_ff @(posedge CLK) begin
    if (!RST_N || !thr.run) begin
      slot_cnt_reg <= 16'h0000;
      slot_idx_reg <= 3'h0;
    end else if (slot_end) begin
      slot_cnt_reg <= 16'h0000;
      slot_idx_reg <= 3'(slot_idx_reg + 3'h1);
    end else begin
      slot_cnt_reg <= 16'(slot_cnt_reg + 16'h0001);
    end
  end

  // registered duty output
  always_ff @(posedge CLK) begin
    if (!RST_N) stop_reg <= 1'b0;
    else        stop_reg <= stop_next;
  end

  assign thr.stop = stop_reg;

  // =====================================================================
  // checks
  // =====================================================================
  property p_duty_slots;
    @(posedge CLK) disable iff (!RST_N)
      (thr.run && thr.ratio != 3'h0) |=>
        (stop_reg == ({1'b0, $past(slot_idx_reg)} < 4'(4'h8 - {1'b0, $past(thr.ratio)})));
  endproperty
  a_duty_slots: assert property (p_duty_slots) else $error("duty slot count wrong");

  property p_duty_idle;
    @(posedge CLK) disable iff (!RST_N)
      (!thr.run || thr.ratio == 3'h0) |=> !stop_reg;
  endproperty
  a_duty_idle: assert property (p_duty_idle) else $error("stop asserted while idle");

  c_duty_wrap: cover property (@(posedge CLK) disable iff (!RST_N)
    thr.run && slot_end && slot_idx_reg == 3'h7);

endmodule : pspc_duty_gen

//--- rtl/pspc_pin_ctrl.sv
`timescale 1ns/1ns
// =====================================================================
// power state pin control
// =====================================================================
//
// Contract
// - C2 enables in byte 0, C3 in byte 1, powered-on suspend in byte 2.
// - stop-clock asserted in a state only if enabled; otherwise no outputs for it.
// - cache sleep follows its state enable, only when its pin function selected.
// - DRAM stop output follows its state enable, active low.
// - CPU and PCI clock stop follow enables, each gated by pin function select.
// - processor sleep follows its enable when the pin function is selected.
// - suspend follows its enable and pin select; held high when enable clear.
// - processor reset pulses on return to full-on from an enabled state.
// - timer interrupt 0 suppressed from suspend command through suspend when bit set.
// - three-bit ratio codes 1 to 7 give 87.5 down to 12.5 percent.
// - thermal throttle when enabled and thermal input asserted.
// - thermal throttling beats normal throttling, off in all sleep states.
// - lock bit set-only, cleared by reset, freezes thermal enable and ratio.
// - write that sets lock still updates thermal enable and ratio.
// - interrupt bus clock kept in suspend if enabled, else low after stop-grant.
// - register at function 3 offset 50h, resets to 1800_0000h.
module pspc_pin_ctrl #(
  parameter int RESET_CYC = pspc_pkg::CPU_RESET_CYC,
  parameter int SLOT_CYC  = pspc_pkg::SLOT_CYC
) (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RST_N,
  // configuration space access
  input  wire logic [2:0]  CFG_FUNC,
  input  wire logic [7:0]  CFG_OFFSET,
  input  wire logic [3:0]  CFG_BE,
  input  wire logic        CFG_WR,
  input  wire logic        CFG_RD,
  input  wire logic [31:0] CFG_WDATA,
  output logic      [31:0] CFG_RDATA,
  output logic             CFG_ACK,
  // power management side
  input  wire logic [2:0]  PWR_STATE,
  input  wire logic [4:0]  PIN_FUNC_SEL,
  input  wire logic        NORM_THROTTLE_STOP,
  input  wire logic        SUSPEND_ENTRY_CMD,
  input  wire logic        STOP_GRANT_DONE,
  input  wire logic        PIT_IRQ0_IN,
  // pins
  input  wire logic        THERMAL_ALERT_IN_N,
  output logic             STOP_CLOCK_OUT_N,
  output logic             CACHE_SLEEP_OUT,
  output logic             DRAM_STOP_OUT_N,
  output logic             CPU_CLOCK_STOP_OUT_N,
  output logic             PCI_CLOCK_STOP_OUT_N,
  output logic             PROCESSOR_SLEEP_OUT_N,
  output logic             SUSPEND_OUT_N,
  output logic             PROCESSOR_RESET_OUT_N,
  output logic             IRQ0_OUT,
  output logic             INTERRUPT_BUS_CLOCK_RUN
);

  typedef enum logic {PSPC_RST_IDLE, PSPC_RST_PULSE} pspc_rst_state_t;

  logic [31:0]     ctrl_reg, ctrl_next;
  logic [2:0]      prev_state_reg;
  logic            thermal_alert_in_n_s1_reg, thermal_alert_in_n_s2_reg, thermal_alert_in_n_s3_reg;
  logic            thermal_active_reg;
  logic            pos_entry_reg;
  pspc_rst_state_t rst_state_reg, rst_state_next;
  logic [15:0]     rst_cnt_reg;
  logic [15:0]     rst_low_reg;

  pspc_thr_if thr_bus ();

  // =====================================================================
  // configuration register
  // =====================================================================
  wire        cfg_hit  = (CFG_FUNC == pspc_pkg::CFG_FUNC_NUM) &&
                         (CFG_OFFSET[7:2] == pspc_pkg::REG_OFFSET[7:2]);
  wire        hit_wr   = cfg_hit && CFG_WR;
  wire        hit_rd   = cfg_hit && CFG_RD;
  wire        locked   = ctrl_reg[pspc_pkg::LOCK_BIT];
  wire [31:0] be_mask  = {{8{CFG_BE[3]}}, {8{CFG_BE[2]}}, {8{CFG_BE[1]}}, {8{CFG_BE[0]}}};
  wire [31:0] lk_mask  = locked ? pspc_pkg::LOCKABLE_MASK : 32'h0000_0000;
  wire [31:0] wr_mask  = hit_wr ? (be_mask & ~lk_mask & ~pspc_pkg::LOCK_MASK) : 32'h0000_0000;
  wire        lock_set = hit_wr && CFG_BE[3] && CFG_WDATA[pspc_pkg::LOCK_BIT];

  // lock uses the old value, so the setting write still lands
  assign ctrl_next = (ctrl_reg & ~wr_mask) | (CFG_WDATA & wr_mask) |
                     (lock_set ? pspc_pkg::LOCK_MASK : 32'h0000_0000);

  // register and read answer
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ctrl_reg  <= pspc_pkg::REG_RESET;
      CFG_RDATA <= 32'h0000_0000;
      CFG_ACK   <= 1'b0;
    end else begin
      ctrl_reg  <= ctrl_next;
      CFG_RDATA <= hit_rd ? ctrl_reg : 32'h0000_0000;
      CFG_ACK   <= CFG_RD || CFG_WR;
    end
  end

  // =====================================================================
  // state pin enables
  // =====================================================================
  wire [7:0] cur_byte  = pspc_pkg::state_byte(ctrl_reg, PWR_STATE);
  wire [7:0] prev_byte = pspc_pkg::state_byte(ctrl_reg, prev_state_reg);
  wire       in_low    = pspc_pkg::is_low_state(PWR_STATE);
  wire       stop_en   = in_low && cur_byte[pspc_pkg::EN_STOP_CLOCK];
  wire       in_sleep  = in_low || (PWR_STATE == pspc_pkg::PS_STR) ||
                         (PWR_STATE == pspc_pkg::PS_STD) || (PWR_STATE == pspc_pkg::PS_SOFT_OFF_STATE);

  wire cache_on = stop_en && cur_byte[pspc_pkg::EN_CACHE_SLEEP] &&
                  PIN_FUNC_SEL[pspc_pkg::FSEL_CACHE_SLEEP];
  wire dram_on  = stop_en && cur_byte[pspc_pkg::EN_DRAM_STOP];
  wire cpu_on   = stop_en && cur_byte[pspc_pkg::EN_CPU_STOP] &&
                  PIN_FUNC_SEL[pspc_pkg::FSEL_CPU_STOP];
  wire pci_on   = stop_en && cur_byte[pspc_pkg::EN_PCI_STOP] &&
                  PIN_FUNC_SEL[pspc_pkg::FSEL_PCI_STOP];
  wire sleep_on = stop_en && cur_byte[pspc_pkg::EN_PROC_SLEEP] &&
                  PIN_FUNC_SEL[pspc_pkg::FSEL_PROC_SLEEP];
  wire susp_on  = stop_en && cur_byte[pspc_pkg::EN_SUSPEND] &&
                  PIN_FUNC_SEL[pspc_pkg::FSEL_SUSPEND];

  // =====================================================================
  // thermal throttling
  // =====================================================================
  // thermal pin synchroniser, change taken once stages two and three agree
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      thermal_alert_in_n_s1_reg       <= 1'b1;
      thermal_alert_in_n_s2_reg       <= 1'b1;
      thermal_alert_in_n_s3_reg       <= 1'b1;
      thermal_active_reg <= 1'b0;
    end else begin
      thermal_alert_in_n_s1_reg <= THERMAL_ALERT_IN_N;
      thermal_alert_in_n_s2_reg <= thermal_alert_in_n_s1_reg;
      thermal_alert_in_n_s3_reg <= thermal_alert_in_n_s2_reg;
      if (thermal_alert_in_n_s2_reg == thermal_alert_in_n_s3_reg) thermal_active_reg <= !thermal_alert_in_n_s3_reg;
    end
  end

  wire [2:0] ratio     = ctrl_reg[pspc_pkg::RATIO_LSB +: 3];
  // only in full-on with a legal ratio; all sleep states suppress it
  wire       thermal_alert_in_n_run = ctrl_reg[pspc_pkg::THERMAL_ALERT_IN_N_EN_BIT] && thermal_active_reg &&
                         !in_sleep && (ratio != 3'h0);

  assign thr_bus.run   = thermal_alert_in_n_run;
  assign thr_bus.ratio = ratio;

  pspc_duty_gen #(
    .SLOT_CYC (SLOT_CYC)
  ) u_duty (
    .CLK   (CLK),
    .RST_N (RST_N),
    .thr   (thr_bus.gen)
  );

  // low-power enable first, then thermal over normal throttling
  wire stop_on = in_low ? stop_en : (thermal_alert_in_n_run ? thr_bus.stop : NORM_THROTTLE_STOP);

  // =====================================================================
  // suspend entry tracking
  // =====================================================================
  // set by the entry command, cleared on return to full-on; set wins
  always_ff @(posedge CLK) begin
    if (!RST_N)                                   pos_entry_reg <= 1'b0;
    else if (SUSPEND_ENTRY_CMD)                   pos_entry_reg <= 1'b1;
    else if (PWR_STATE == pspc_pkg::PS_FULL_ON)   pos_entry_reg <= 1'b0;
  end

  wire irq0_block = pos_entry_reg && ctrl_reg[pspc_pkg::TIMER_SUPPRESS_BIT];
  wire clk_drop   = pos_entry_reg && STOP_GRANT_DONE &&
                    !ctrl_reg[pspc_pkg::INTBUS_KEEP_BIT];

  // =====================================================================
  // processor reset on return to full-on
  // =====================================================================
  wire crst_trig = (PWR_STATE == pspc_pkg::PS_FULL_ON) &&
                   pspc_pkg::is_low_state(prev_state_reg) &&
                   prev_byte[pspc_pkg::EN_STOP_CLOCK] && prev_byte[pspc_pkg::EN_PROC_RESET];
  wire rst_last  = (rst_cnt_reg == 16'(RESET_CYC - 1));

  // pulse sequencer next state
  always_comb begin
    rst_state_next = rst_state_reg;
    unique case (rst_state_reg)
      PSPC_RST_IDLE:  if (crst_trig) rst_state_next = PSPC_RST_PULSE;
      PSPC_RST_PULSE: if (rst_last) rst_state_next = PSPC_RST_IDLE;
    endcase
  end

  // pulse sequencer registers
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      rst_state_reg  <= PSPC_RST_IDLE;
      rst_cnt_reg    <= 16'h0000;
      prev_state_reg <= pspc_pkg::PS_FULL_ON;
    end else begin
      rst_state_reg  <= rst_state_next;
      rst_cnt_reg    <= (rst_state_reg == PSPC_RST_PULSE) ? 16'(rst_cnt_reg + 16'h0001)
                                                          : 16'h0000;
      prev_state_reg <= PWR_STATE;
    end
  end

  // =====================================================================
  // output flops
  // =====================================================================
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      STOP_CLOCK_OUT_N        <= 1'b1;
      CACHE_SLEEP_OUT         <= 1'b0;
      DRAM_STOP_OUT_N         <= 1'b1;
      CPU_CLOCK_STOP_OUT_N    <= 1'b1;
      PCI_CLOCK_STOP_OUT_N    <= 1'b1;
      PROCESSOR_SLEEP_OUT_N   <= 1'b1;
      SUSPEND_OUT_N           <= 1'b1;
      PROCESSOR_RESET_OUT_N   <= 1'b1;
      IRQ0_OUT                <= 1'b0;
      INTERRUPT_BUS_CLOCK_RUN <= 1'b1;
    end else begin
      STOP_CLOCK_OUT_N        <= !stop_on;
      CACHE_SLEEP_OUT         <= cache_on;
      DRAM_STOP_OUT_N         <= !dram_on;
      CPU_CLOCK_STOP_OUT_N    <= !cpu_on;
      PCI_CLOCK_STOP_OUT_N    <= !pci_on;
      PROCESSOR_SLEEP_OUT_N   <= !sleep_on;
      SUSPEND_OUT_N           <= !susp_on;
      PROCESSOR_RESET_OUT_N   <= !(rst_state_next == PSPC_RST_PULSE);
      IRQ0_OUT                <= PIT_IRQ0_IN && !irq0_block;
      if (PWR_STATE == pspc_pkg::PS_FULL_ON) INTERRUPT_BUS_CLOCK_RUN <= 1'b1;
      else if (clk_drop)                     INTERRUPT_BUS_CLOCK_RUN <= 1'b0;
    end
  end

  // =====================================================================
  // checks
  // =====================================================================
  property p_c3_byte;
    @(posedge CLK) disable iff (!RST_N)
      (PWR_STATE == pspc_pkg::PS_C3) |=>
        (DRAM_STOP_OUT_N == !($past(ctrl_reg[10]) && $past(ctrl_reg[9])));
  endproperty
  a_c3_byte: assert property (p_c3_byte) else $error("C3 byte not used");

  property p_stop_gate;
    @(posedge CLK) disable iff (!RST_N)
      (in_low && !cur_byte[pspc_pkg::EN_STOP_CLOCK]) |=>
        (STOP_CLOCK_OUT_N && !CACHE_SLEEP_OUT && DRAM_STOP_OUT_N && CPU_CLOCK_STOP_OUT_N &&
         PCI_CLOCK_STOP_OUT_N && PROCESSOR_SLEEP_OUT_N && SUSPEND_OUT_N);
  endproperty
  a_stop_gate: assert property (p_stop_gate) else $error("output without stop enable");

  property p_cache_sel;
    @(posedge CLK) disable iff (!RST_N)
      !PIN_FUNC_SEL[pspc_pkg::FSEL_CACHE_SLEEP] |=> !CACHE_SLEEP_OUT;
  endproperty
  a_cache_sel: assert property (p_cache_sel) else $error("cache sleep without select");

  property p_cpu_stop;
    @(posedge CLK) disable iff (!RST_N)
      (stop_en && cur_byte[pspc_pkg::EN_CPU_STOP] && PIN_FUNC_SEL[pspc_pkg::FSEL_CPU_STOP])
        |=> !CPU_CLOCK_STOP_OUT_N;
  endproperty
  a_cpu_stop: assert property (p_cpu_stop) else $error("cpu clock stop missing");

  property p_susp_high;
    @(posedge CLK) disable iff (!RST_N)
      !cur_byte[pspc_pkg::EN_SUSPEND] |=> SUSPEND_OUT_N;
  endproperty
  a_susp_high: assert property (p_susp_high) else $error("suspend with enable clear");

  // check helper: length of the current low run on the processor reset pin
  always_ff @(posedge CLK) begin
    if (!RST_N || PROCESSOR_RESET_OUT_N) rst_low_reg <= 16'h0000;
    else                                 rst_low_reg <= 16'(rst_low_reg + 16'h0001);
  end

  property p_reset_pulse;
    @(posedge CLK) disable iff (!RST_N)
      (crst_trig && rst_state_reg == PSPC_RST_IDLE) |=>
        !PROCESSOR_RESET_OUT_N ##[1:1000]
          (PROCESSOR_RESET_OUT_N && rst_low_reg == 16'(RESET_CYC));
  endproperty
  a_reset_pulse: assert property (p_reset_pulse) else $error("reset pulse wrong");

  property p_irq0_block;
    @(posedge CLK) disable iff (!RST_N)
      (SUSPEND_ENTRY_CMD && ctrl_reg[pspc_pkg::TIMER_SUPPRESS_BIT] &&
       !hit_wr) ##1 (PWR_STATE != pspc_pkg::PS_FULL_ON && !hit_wr) |=> !IRQ0_OUT;
  endproperty
  a_irq0_block: assert property (p_irq0_block) else $error("timer irq not suppressed");

  property p_thermal_alert_in_n_sleep;
    @(posedge CLK) disable iff (!RST_N)
      in_sleep |=> !thr_bus.stop;
  endproperty
  a_thermal_alert_in_n_sleep: assert property (p_thermal_alert_in_n_sleep) else $error("thermal throttle in sleep");

  property p_lock_hold;
    @(posedge CLK) disable iff (!RST_N)
      locked |=> (ctrl_reg[28:25] == $past(ctrl_reg[28:25])) && locked;
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("locked field changed");

  property p_lock_same_write;
    @(posedge CLK) disable iff (!RST_N)
      (lock_set && !locked) |=> (ctrl_reg[28:25] == $past(CFG_WDATA[28:25]));
  endproperty
  a_lock_same_write: assert property (p_lock_same_write) else $error("lock write lost");

  property p_intbus_drop;
    @(posedge CLK) disable iff (!RST_N)
      (clk_drop && PWR_STATE != pspc_pkg::PS_FULL_ON) |=> !INTERRUPT_BUS_CLOCK_RUN;
  endproperty
  a_intbus_drop: assert property (p_intbus_drop) else $error("bus clock not stopped");

  property p_reset_value;
    @(posedge CLK) !RST_N |=> (ctrl_reg == pspc_pkg::REG_RESET);
  endproperty
  a_reset_value: assert property (p_reset_value) else $error("bad reset value");

  c_thermal_alert_in_n_throttle: cover property (@(posedge CLK) disable iff (!RST_N)
    thermal_alert_in_n_run && !STOP_CLOCK_OUT_N);
  c_proc_reset: cover property (@(posedge CLK) disable iff (!RST_N)
    crst_trig && rst_state_reg == PSPC_RST_IDLE);
  c_lock_write: cover property (@(posedge CLK) disable iff (!RST_N) lock_set && !locked);

endmodule : pspc_pin_ctrl

//--- rtl/pspc_pkg.sv
// =====================================================================
// power state pin control constants
// =====================================================================
package pspc_pkg;

  // configuration space placement and reset value
  localparam logic [2:0]  CFG_FUNC_NUM  = 3'h3;
  localparam logic [7:0]  REG_OFFSET    = 8'h50;
  localparam logic [31:0] REG_RESET     = 32'h1800_0000;
  localparam logic [31:0] LOCKABLE_MASK = 32'h1E00_0000;  // enable and ratio
  localparam logic [31:0] LOCK_MASK     = 32'h2000_0000;

  // per-state enable bytes
  localparam int C2_LSB  = 0;
  localparam int C3_LSB  = 8;
  localparam int POS_LSB = 16;

  // bit positions inside one state byte
  localparam int EN_CACHE_SLEEP = 0;
  localparam int EN_DRAM_STOP   = 1;
  localparam int EN_STOP_CLOCK  = 2;
  localparam int EN_CPU_STOP    = 3;
  localparam int EN_PCI_STOP    = 4;
  localparam int EN_PROC_SLEEP  = 5;
  localparam int EN_SUSPEND     = 6;
  localparam int EN_PROC_RESET  = 7;

  // upper byte fields
  localparam int TIMER_SUPPRESS_BIT = 24;
  localparam int RATIO_LSB          = 25;
  localparam int THERMAL_ALERT_IN_N_EN_BIT       = 28;
  localparam int LOCK_BIT           = 29;
  localparam int INTBUS_KEEP_BIT    = 31;

  // power state codes presented by the power management logic
  localparam logic [2:0] PS_FULL_ON = 3'h0;
  localparam logic [2:0] PS_C2      = 3'h1;
  localparam logic [2:0] PS_C3      = 3'h2;
  localparam logic [2:0] PS_POS     = 3'h3;
  localparam logic [2:0] PS_STR     = 3'h4;
  localparam logic [2:0] PS_STD     = 3'h5;
  localparam logic [2:0] PS_SOFT_OFF_STATE    = 3'h6;

  // pin function select indices
  localparam int FSEL_CACHE_SLEEP = 0;
  localparam int FSEL_CPU_STOP    = 1;
  localparam int FSEL_PCI_STOP    = 2;
  localparam int FSEL_PROC_SLEEP  = 3;
  localparam int FSEL_SUSPEND     = 4;

  // timing
  localparam int CLK_PERIOD_NS  = 10;
  localparam int CPU_RESET_NS   = 1000;
  localparam int CPU_RESET_CYC  = (CPU_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLOT_NS        = 1000;
  localparam int SLOT_CYC       = (SLOT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int THROTTLE_SLOTS = 8;

  // low-power states with a pin enable byte
  function automatic logic is_low_state(input logic [2:0] st);
    return (st == PS_C2) || (st == PS_C3) || (st == PS_POS);
  endfunction : is_low_state

  // enable byte of a state, zero outside the low-power states
  function automatic logic [7:0] state_byte(input logic [31:0] ctrl, input logic [2:0] st);
    logic [7:0] b;
    b = 8'h00;
    if (st == PS_C2) b = ctrl[C2_LSB +: 8];
    if (st == PS_C3) b = ctrl[C3_LSB +: 8];
    if (st == PS_POS) b = ctrl[POS_LSB +: 8];
    return b;
  endfunction : state_byte

endpackage : pspc_pkg

//--- rtl/pspc_thr_if.sv
`timescale 1ns/1ns
// =====================================================================
// throttle duty generator link
// =====================================================================
interface pspc_thr_if;
  logic       run;    // throttling requested
  logic [2:0] ratio;  // duty ratio code
  logic       stop;   // stop-clock request, active high
  modport ctl (output run, output ratio, input stop);
  modport gen (input run, input ratio, output stop);
endinterface : pspc_thr_if

//--- verification/pspc_far_model.sv
`timescale 1ns/1ns
// =====================================================================
// processor and thermal sensor stand-in
// =====================================================================
module pspc_far_model (
  // clock
  input  wire logic CLK,
  // sensor request and processor pins
  input  wire logic HOT,
  input  wire logic STOP_CLOCK_N,
  output logic      THERMAL_ALERT_IN_N_N,
  output logic      GRANT,
  output int        STOP_CNT
);
  logic [1:0] fall_q;
  // sensor pin, active low
  assign THERMAL_ALERT_IN_N_N = ~HOT;
  // stop-grant two clocks after stop-clock falls; count stopped cycles
  always @(posedge CLK) begin
    fall_q   <= {fall_q[0], ~STOP_CLOCK_N};
    GRANT    <= fall_q[0] & ~fall_q[1];
    STOP_CNT <= STOP_CNT + (STOP_CLOCK_N ? 0 : 1);
  end
  initial begin
    fall_q = 2'h0;
    GRANT = 1'b0;
    STOP_CNT = 0;
  end
endmodule : pspc_far_model

//--- verification/tb_top.sv
`timescale 1ns/1ns
// =====================================================================
// power state pin control bench
// =====================================================================
module tb_top;
  localparam int RC = 4;
  localparam int SC = 4;
  logic        clk = 1'b0, rst_n = 1'b0, wr_s = 1'b0, rd_s = 1'b0, ack;
  logic [2:0]  fn = 3'h3, pst = 3'h0;
  logic [7:0]  off = 8'h50;
  logic [31:0] wd = 32'h0, rdat, rq;
  logic [4:0]  sel = 5'h1F;
  logic [3:0]  be = 4'hF;
  logic        nts = 1'b0, cmd = 1'b0, pit = 1'b0, hot = 1'b0, grant, thermal_alert_in_n_n;
  logic        stop_n, cache, dram_n, cpu_n, pci_n, slp_n, susp_n, crst_n, irq0, run;
  int          stop_cnt, cyc_cnt = 0, n_errors = 0, total_checks = 0;
  wire  [6:0]  pins = {~susp_n, ~slp_n, ~pci_n, ~cpu_n, ~stop_n, ~dram_n, cache};

  pspc_pin_ctrl #(.RESET_CYC(RC), .SLOT_CYC(SC)) u_dut (
    .CLK(clk), .RST_N(rst_n), .CFG_FUNC(fn), .CFG_OFFSET(off), .CFG_BE(be),
    .CFG_WR(wr_s), .CFG_RD(rd_s), .CFG_WDATA(wd), .CFG_RDATA(rdat), .CFG_ACK(ack),
    .PWR_STATE(pst), .PIN_FUNC_SEL(sel), .NORM_THROTTLE_STOP(nts),
    .SUSPEND_ENTRY_CMD(cmd), .STOP_GRANT_DONE(grant), .PIT_IRQ0_IN(pit),
    .THERMAL_ALERT_IN_N(thermal_alert_in_n_n), .STOP_CLOCK_OUT_N(stop_n), .CACHE_SLEEP_OUT(cache),
    .DRAM_STOP_OUT_N(dram_n), .CPU_CLOCK_STOP_OUT_N(cpu_n), .PCI_CLOCK_STOP_OUT_N(pci_n),
    .PROCESSOR_SLEEP_OUT_N(slp_n), .SUSPEND_OUT_N(susp_n),
    .PROCESSOR_RESET_OUT_N(crst_n), .IRQ0_OUT(irq0), .INTERRUPT_BUS_CLOCK_RUN(run));
  pspc_far_model u_far (.CLK(clk), .HOT(hot), .STOP_CLOCK_N(stop_n), .THERMAL_ALERT_IN_N_N(thermal_alert_in_n_n),
    .GRANT(grant), .STOP_CNT(stop_cnt));

  // clock and hang guard
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 6000) begin
      n_errors++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic rst();
    @(negedge clk);
    rst_n = 1'b0;
    cyc(2);
    rst_n = 1'b1;
  endtask : rst
  // one strobe cycle, answer taken the cycle after
  task automatic cfg(input logic w, input logic [2:0] f, input logic [7:0] o,
                     input logic [31:0] d);
    @(negedge clk);
    wr_s = w;
    rd_s = ~w;
    fn = f;
    off = o;
    wd = d;
    @(negedge clk);
    wr_s = 1'b0;
    rd_s = 1'b0;
    rq = rdat;
    chk(ack, 1'b1);
  endtask : cfg
  task automatic wr(input logic [2:0] f, input logic [31:0] d);
    cfg(1'b1, f, 8'h50, d);
  endtask : wr
  task automatic rd(input logic [7:0] o, input logic [31:0] e);
    cfg(1'b0, 3'h3, o, 32'h0);
    chk(rq, e);
  endtask : rd
  // stop-clock cycles over two whole throttle periods
  task automatic stop_chk(input int e);
    int c0;
    cyc(8 * SC + 10);
    c0 = stop_cnt;
    cyc(16 * SC);
    chk(stop_cnt - c0, e);
  endtask : stop_chk

  task automatic t_reset();
    rd(8'h50, 32'h1800_0000);
    chk({25'h0, pins}, 32'h0);
    wr(3'h0, 32'hFFFF_FFFF);
    rd(8'h54, 32'h0);
    rd(8'h53, 32'h1800_0000);
  endtask : t_reset
  task automatic t_states();
    logic [7:0] b, m;
    for (int s = 1; s < 4; s++) begin
      for (int k = 0; k < 4; k++) begin
        b = k[0] ? 8'h7B : 8'h7F;
        sel = k[1] ? 5'h00 : 5'h1F;
        m = {1'b0, sel[4:1], 2'h3, sel[0]} & b;
        wr(3'h3, 32'(b) << (8 * (s - 1)));
        pst = 3'(s);
        cyc(2);
        chk({25'h0, pins}, {25'h0, b[2] ? m[6:0] : 7'h0});
        pst = 3'h0;
        cyc(2);
      end
    end
    sel = 5'h1F;
  endtask : t_states
  task automatic t_crst();
    int n;
    for (int k = 0; k < 2; k++) begin
      wr(3'h3, k ? 32'h0000_4400 : 32'h0000_C400);
      pst = 3'h2;
      cyc(3);
      pst = 3'h0;
      n = 0;
      repeat (RC + 10) begin
        @(negedge clk);
        n += !crst_n;
      end
      chk(n, k ? 0 : RC);
    end
  endtask : t_crst
  task automatic t_thermal_alert_in_n();
    hot = 1'b1;
    nts = 1'b1;
    for (int r = 1; r < 8; r++) begin
      wr(3'h3, 32'h1000_0000 | (r << 25));
      stop_chk(2 * (8 - r) * SC);
    end
    nts = 1'b0;
    for (int s = 1; s < 7; s++) begin
      pst = 3'(s);
      stop_chk(0);
    end
    pst = 3'h0;
    wr(3'h3, 32'h0);
    stop_chk(0);
    hot = 1'b0;
  endtask : t_thermal_alert_in_n
  task automatic t_pos();
    for (int k = 0; k < 2; k++) begin
      wr(3'h3, k ? 32'h8004_0000 : 32'h0104_0000);
      pit = 1'b1;
      cmd = 1'b1;
      @(negedge clk);
      cmd = 1'b0;
      pst = 3'h3;
      cyc(8);
      chk({irq0, run}, {2{k[0]}});
      pst = 3'h0;
      cyc(3);
      chk({irq0, run}, 2'h3);
      pit = 1'b0;
    end
  endtask : t_pos
  task automatic t_lock();
    be = 4'h7;
    wr(3'h3, 32'hFFFF_FFFF);
    be = 4'hF;
    rd(8'h50, 32'h80FF_FFFF);
    wr(3'h3, 32'h7E00_0000);
    rd(8'h50, 32'h7E00_0000);
    wr(3'h3, 32'h0);
    rd(8'h50, 32'h3E00_0000);
    rst();
    rd(8'h50, 32'h1800_0000);
  endtask : t_lock

  initial begin
    cyc(2);
    rst_n = 1'b1;
    t_reset();
    t_states();
    t_crst();
    t_thermal_alert_in_n();
    t_pos();
    t_lock();
    conclude();
  end
endmodule : tb_top
